/* verilog/sfl_core.sv */
// How it works
// RULE1 - program allowed in erase suspend, not erasing sector
// RULE2 - host sends write enable before program
// RULE3 - program inside suspend not suspendable; resume waits
// RULE4 - latch and busy high during suspended program
// RULE5 - suspended flag reported at status bit 15
// RULE6 - resume sets latch, busy; clears suspended
// RULE7 - host waits resume-to-suspend time before suspending
// RULE8 - no-operation only cancels pending reset arm
// RULE9 - protection select picks lock bits or protect bits
// RULE10 - lock bits volatile, all set after reset
// RULE11 - single lock sets addressed block or sector
// RULE12 - single unlock clears addressed block or sector
// RULE13 - host sends write enable before lock commands
// RULE14 - lock commands need chip select on byte boundary
// RULE15 - lock status read returns addressed lock bit
// RULE16 - opcode taken as 8 single or 2 quad clocks
// RULE17 - global lock sets every lock bit
// RULE18 - global unlock clears every lock bit
// RULE19 - reset acts only right after reset arm
// RULE20 - soft reset restores defaults, keeps failure flag
// RULE21 - soft reset aborts running program or erase
// RULE22 - unique id read: opcode, four dummies, 128 bits
// RULE23 - suspend takes effect after the suspend latency
// RULE24 - program or erase to locked unit refused
`timescale 1ns/1ps
`include "sfl_regs.svh"
module sfl_core import sfl_pkg::*; #(
  parameter int PROG_CYCLES = `SFL_PROG_TIME_NS / `SFL_CLK_PERIOD_NS,
  parameter int ERASE_CYCLES = `SFL_ERASE_TIME_NS / `SFL_CLK_PERIOD_NS,
  parameter logic [127:0] UNIQUE_ID = `SFL_UID_DEFAULT // arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  input wire logic i_quad_command_mode,
  input wire logic i_protection_select,
  input wire logic i_protect_complement,
  input wire logic [4:0] i_block_protect_bits,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  output sfl_status_t o_status
);
  localparam logic [9:0] SUSP_LAT = 10'(`SFL_SUSP_LAT_CYC);

  sfl_pins_t pins_s;
  logic sclk_d;
  logic cs_n_d;
  logic [31:0] shreg;
  logic [7:0] bit_cnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [127:0] out_sr;
  logic out_active;
  sfl_op_t state;
  logic wr_latch;
  logic fail;
  logic reset_armed;
  logic susp_erase;
  logic [6:0] erase_sector;
  logic [31:0] op_cnt;
  logic [31:0] susp_prog_cnt;
  logic [9:0] lat_cnt;
  sfl_lock_op_t lock_op;
  logic [18:0] lock_wr_addr;
  logic locked;

  logic rise;
  logic fall;
  logic cs_rise;
  logic [7:0] step;
  logic [7:0] next_cnt;
  logic [31:0] next_shreg;
  logic [7:0] cur_op;
  logic [18:0] lock_rd_addr;
  logic [15:0] status_word;
  logic prot;
  logic has_op;
  logic writable_state;

  sfl_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_pins({i_cs_n, i_sclk, i_io}),
    .o_pins(pins_s)
  );

  sfl_lock_mem u_lock (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_op(lock_op),
    .i_wr_addr(lock_wr_addr),
    .i_rd_addr(lock_rd_addr),
    .o_locked(locked)
  );

  function automatic logic bp_protect(input logic [4:0] bp, input logic cmp,
                                      input logic [2:0] blk);
    logic in_region;
    in_region = (bp > {2'b00, 3'h7 - blk});
    bp_protect = in_region ^ cmp;
  endfunction

  function automatic logic is_busy(input sfl_op_t s);
    is_busy = (s == OP_PROG) || (s == OP_ERASE) || (s == OP_SUSP_LAT) ||
              (s == OP_SUSP_PROG);
  endfunction

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else if (i_clk_en) begin
      sclk_d <= pins_s.sclk;
      cs_n_d <= pins_s.cs_n;
    end
  end

  assign rise = pins_s.sclk & ~sclk_d & ~pins_s.cs_n;
  assign fall = ~pins_s.sclk & sclk_d & ~pins_s.cs_n;
  assign cs_rise = pins_s.cs_n & ~cs_n_d;
  assign step = i_quad_command_mode ? 8'd4 : 8'd1;
  assign next_cnt = (bit_cnt > 8'd250) ? bit_cnt : bit_cnt + step;
  assign next_shreg = i_quad_command_mode ? {shreg[27:0], pins_s.io} :
                      {shreg[30:0], pins_s.io[0]};
  assign cur_op = (next_cnt == `SFL_BITS_OP) ? next_shreg[7:0] : opcode;
  assign lock_rd_addr = (rise && next_cnt == `SFL_BITS_ADDR) ? next_shreg[18:0] :
                        addr[18:0];
  assign status_word = {o_status.suspended, i_protect_complement, 7'h00, // RULE5
                        i_block_protect_bits, o_status.write_enable_latch,
                        o_status.busy};
  assign prot = i_protection_select ? locked : // RULE9
                bp_protect(i_block_protect_bits, i_protect_complement, addr[18:16]);
  assign has_op = (bit_cnt >= `SFL_BITS_OP);
  assign writable_state = (state == OP_IDLE) || (state == OP_SUSPENDED);

  // serial receive: 1 or 4 bits per clock in every phase
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg <= 32'h0;
      bit_cnt <= 8'h0;
      opcode <= 8'h0;
      addr <= 24'h0;
    end else if (i_clk_en) begin
      if (pins_s.cs_n) begin
        bit_cnt <= 8'h0;
      end else if (rise) begin
        shreg <= next_shreg;
        bit_cnt <= next_cnt;
        if (next_cnt == `SFL_BITS_OP) opcode <= next_shreg[7:0]; // RULE16
        if (next_cnt == `SFL_BITS_ADDR) addr <= next_shreg[23:0];
      end
    end
  end

  // serial transmit: loaded on the last input clock, shifted on falling edges
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_sr <= 128'h0;
      out_active <= 1'b0;
      o_io_out <= 4'h0;
      o_io_oe <= 4'h0;
    end else if (i_clk_en) begin
      if (pins_s.cs_n) begin
        out_active <= 1'b0;
        o_io_oe <= 4'h0;
      end else if (rise && !out_active) begin
        if (next_cnt == `SFL_BITS_OP && cur_op == `SFL_OP_STATUS_LO) begin
          out_sr <= {{16{status_word[7:0]}}};
          out_active <= 1'b1;
        end else if (next_cnt == `SFL_BITS_OP && cur_op == `SFL_OP_STATUS_HI) begin
          out_sr <= {{16{status_word[15:8]}}};
          out_active <= 1'b1;
        end else if (next_cnt == `SFL_BITS_ADDR && opcode == `SFL_OP_RDLOCK) begin
          out_sr <= {7'h00, locked, 120'h0}; // RULE15
          out_active <= 1'b1;
        end else if (next_cnt == `SFL_BITS_UNIQUE_ID && opcode == `SFL_OP_UNIQUE_ID) begin
          out_sr <= UNIQUE_ID; // RULE22
          out_active <= 1'b1;
        end
      end else if (fall && out_active) begin
        if (i_quad_command_mode) begin
          o_io_out <= out_sr[127:124];
          o_io_oe <= 4'hf;
          out_sr <= {out_sr[123:0], 4'h0};
        end else begin
          o_io_out <= {2'b00, out_sr[127], 1'b0};
          o_io_oe <= 4'b0010;
          out_sr <= {out_sr[126:0], 1'b0};
        end
      end
    end
  end

  // reset arm: only the very next command may use it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      reset_armed <= 1'b0;
    end else if (i_clk_en && cs_rise && has_op) begin
      reset_armed <= (opcode == `SFL_OP_RSTARM); // RULE19 RULE8
    end
  end

  // operation sequencer, write latch, lock commands
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= OP_IDLE;
      wr_latch <= 1'b0;
      fail <= 1'b0;
      susp_erase <= 1'b0;
      erase_sector <= 7'h0;
      op_cnt <= 32'h0;
      susp_prog_cnt <= 32'h0;
      lat_cnt <= 10'h0;
      lock_op <= LK_NONE;
      lock_wr_addr <= 19'h0;
    end else if (i_clk_en) begin
      lock_op <= LK_NONE;
      case (state)
        OP_PROG, OP_ERASE: begin
          if (op_cnt <= 32'd1) begin
            state <= OP_IDLE;
            wr_latch <= 1'b0;
          end
          op_cnt <= op_cnt - 32'd1;
        end
        OP_SUSP_LAT: begin
          if (lat_cnt <= 10'd1) begin
            state <= OP_SUSPENDED; // RULE23
            wr_latch <= 1'b0;
          end
          lat_cnt <= lat_cnt - 10'd1;
        end
        OP_SUSP_PROG: begin
          if (susp_prog_cnt <= 32'd1) begin
            state <= OP_SUSPENDED; // RULE4
            wr_latch <= 1'b0;
          end
          susp_prog_cnt <= susp_prog_cnt - 32'd1;
        end
        OP_IDLE, OP_SUSPENDED: begin
        end
        default: state <= OP_IDLE;
      endcase
      if (cs_rise && has_op) begin
        case (opcode)
          `SFL_OP_WRITE_ENABLE: if (writable_state) wr_latch <= 1'b1;
          `SFL_OP_PROG: begin
            if (bit_cnt >= `SFL_BITS_DATA && wr_latch && writable_state) begin
              if (prot) begin
                fail <= 1'b1; // RULE24
                wr_latch <= 1'b0;
              end else if (state == OP_IDLE) begin
                state <= OP_PROG;
                op_cnt <= 32'(PROG_CYCLES);
              end else if (susp_erase && addr[18:12] != erase_sector) begin
                state <= OP_SUSP_PROG; // RULE1 RULE4
                susp_prog_cnt <= 32'(PROG_CYCLES);
              end
            end
          end
          `SFL_OP_ERASE: begin
            if (bit_cnt == `SFL_BITS_ADDR && wr_latch && state == OP_IDLE) begin
              if (prot) begin
                fail <= 1'b1; // RULE24
                wr_latch <= 1'b0;
              end else begin
                state <= OP_ERASE;
                op_cnt <= 32'(ERASE_CYCLES);
                erase_sector <= addr[18:12];
              end
            end
          end
          `SFL_OP_SUSPEND: begin
            // a program begun inside a suspend is not in these states
            if (state == OP_PROG || state == OP_ERASE) begin // RULE3
              state <= OP_SUSP_LAT;
              lat_cnt <= SUSP_LAT;
              susp_erase <= (state == OP_ERASE);
            end
          end
          `SFL_OP_RESUME: begin
            if (state == OP_SUSPENDED) begin // RULE3
              state <= susp_erase ? OP_ERASE : OP_PROG; // RULE6
              wr_latch <= 1'b1;
            end
          end
          `SFL_OP_SINGLE_LOCK, `SFL_OP_SINGLE_UNLOCK: begin
            if (bit_cnt == `SFL_BITS_ADDR && wr_latch && writable_state) begin // RULE14
              lock_op <= (opcode == `SFL_OP_SINGLE_LOCK) ? LK_SET : LK_CLR; // RULE11 RULE12
              lock_wr_addr <= addr[18:0];
              wr_latch <= 1'b0;
            end
          end
          `SFL_OP_GLOBAL_LOCK, `SFL_OP_GLOBAL_UNLOCK: begin
            if (bit_cnt == `SFL_BITS_OP && wr_latch && writable_state) begin // RULE14 RULE16
              lock_op <= (opcode == `SFL_OP_GLOBAL_LOCK) ? LK_SET_ALL : LK_CLR_ALL; // RULE17 RULE18
              wr_latch <= 1'b0;
            end
          end
          `SFL_OP_RESET: begin
            if (reset_armed) begin // RULE19
              state <= OP_IDLE; // RULE20 RULE21
              wr_latch <= 1'b0;
              susp_erase <= 1'b0;
              op_cnt <= 32'h0;
              susp_prog_cnt <= 32'h0;
              lat_cnt <= 10'h0;
              lock_op <= LK_SET_ALL; // RULE10
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= '0;
    end else if (i_clk_en) begin
      o_status.write_enable_latch <= wr_latch; // RULE4 RULE6
      o_status.busy <= is_busy(state); // RULE4 RULE6
      o_status.suspended <= (state == OP_SUSPENDED) || (state == OP_SUSP_PROG); // RULE5
      o_status.failure <= fail; // RULE20
    end
  end
endmodule

/* verilog/sfl_regs.svh */
`ifndef SFL_REGS_SVH
`define SFL_REGS_SVH

`define SFL_OP_WRITE_ENABLE 8'h06
`define SFL_OP_PROG 8'h02
`define SFL_OP_ERASE 8'h20
`define SFL_OP_STATUS_LO 8'h05
`define SFL_OP_STATUS_HI 8'h35
`define SFL_OP_SUSPEND 8'h75
`define SFL_OP_RESUME 8'h7a
`define SFL_OP_NO_OPERATION 8'h00
`define SFL_OP_SINGLE_LOCK 8'h36
`define SFL_OP_SINGLE_UNLOCK 8'h39
`define SFL_OP_RDLOCK 8'h3d
`define SFL_OP_GLOBAL_LOCK 8'h7e
`define SFL_OP_GLOBAL_UNLOCK 8'h98
`define SFL_OP_RSTARM 8'h66
`define SFL_OP_RESET 8'h99
`define SFL_OP_UNIQUE_ID 8'h4b

`define SFL_BITS_OP 8'd8
`define SFL_BITS_ADDR 8'd32
`define SFL_BITS_UNIQUE_ID 8'd40
`define SFL_BITS_DATA 8'd40
`define SFL_SUSPENDED_BIT 15

`define SFL_CLK_PERIOD_NS 40
`define SFL_SUSP_LAT_NS 20000
`define SFL_SUSP_LAT_CYC (`SFL_SUSP_LAT_NS / `SFL_CLK_PERIOD_NS)
`define SFL_PROG_TIME_NS 500000
`define SFL_ERASE_TIME_NS 30000000

`define SFL_PINS_IDLE 6'h20
`define SFL_LOCK_RESET {128{1'b1}}
`define SFL_UID_DEFAULT 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210

`endif

/* verilog/sfl_pkg.sv */
package sfl_pkg;

  typedef enum logic [5:0] {
    OP_IDLE = 6'b000001,
    OP_PROG = 6'b000010,
    OP_ERASE = 6'b000100,
    OP_SUSP_LAT = 6'b001000,
    OP_SUSPENDED = 6'b010000,
    OP_SUSP_PROG = 6'b100000
  } sfl_op_t;

  typedef enum logic [4:0] {
    LK_NONE = 5'b00001,
    LK_SET = 5'b00010,
    LK_CLR = 5'b00100,
    LK_SET_ALL = 5'b01000,
    LK_CLR_ALL = 5'b10000
  } sfl_lock_op_t;

  typedef struct packed {
    logic failure;
    logic suspended;
    logic busy;
    logic write_enable_latch;
  } sfl_status_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } sfl_pins_t;

endpackage

/* verilog/sfl_sync.sv */
`timescale 1ns/1ps
`include "sfl_regs.svh"
module sfl_sync import sfl_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire sfl_pins_t i_pins,
  output sfl_pins_t o_pins
);
  sfl_pins_t stage1;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= `SFL_PINS_IDLE;
      o_pins <= `SFL_PINS_IDLE;
    end else if (i_clk_en) begin
      stage1 <= i_pins;
      o_pins <= stage1;
    end
  end
endmodule

/* verilog/sfl_lock_mem.sv */
`timescale 1ns/1ps
`include "sfl_regs.svh"
module sfl_lock_mem import sfl_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire sfl_lock_op_t i_op,
  input wire logic [18:0] i_wr_addr,
  input wire logic [18:0] i_rd_addr,
  output logic o_locked
);
  // one bit per 4 KB sector; outer blocks lock by sector, inner by 64 KB block
  logic [127:0] lock;

  function automatic logic same_unit(input logic [6:0] sec, input logic [18:0] a);
    if (a[18:16] == 3'h0 || a[18:16] == 3'h7)
      same_unit = (sec == a[18:12]);
    else
      same_unit = (sec[6:4] == a[18:16]);
  endfunction

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lock <= `SFL_LOCK_RESET; // RULE10
    end else if (i_clk_en) begin
      for (int i = 0; i < 128; i++) begin
        case (i_op)
          LK_SET: if (same_unit(7'(i), i_wr_addr)) lock[i] <= 1'b1; // RULE11
          LK_CLR: if (same_unit(7'(i), i_wr_addr)) lock[i] <= 1'b0; // RULE12
          LK_SET_ALL: lock[i] <= 1'b1; // RULE17
          LK_CLR_ALL: lock[i] <= 1'b0; // RULE18
          default: lock[i] <= lock[i];
        endcase
      end
    end
  end

  assign o_locked = lock[i_rd_addr[18:12]];
endmodule

/* sim/sfl_core_properties.sv */
`timescale 1ns/1ps
module sfl_core_properties import sfl_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_quad_command_mode,
  input wire logic [3:0] o_io_oe,
  input wire sfl_status_t o_status
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  oe_idle_a: assert property (i_cs_n [*5] |-> o_io_oe == 4'h0)
    else $error("output enable active while deselected");
  oe_mode_a: assert property (o_io_oe != 4'h0 |->
    o_io_oe == (i_quad_command_mode ? 4'hf : 4'h2))
    else $error("output enable pattern wrong for mode");
  sus_prog_a: assert property (o_status.suspended && o_status.busy |->
    o_status.write_enable_latch)
    else $error("latch low during program in suspend");
  resume_pair_a: assert property ($fell(o_status.suspended) |->
    o_status.busy == o_status.write_enable_latch)
    else $error("latch and busy disagree on resume");
  fail_keep_a: assert property (!$fell(o_status.failure))
    else $error("failure flag cleared without hard reset");
  sus_entry_a: assert property ($rose(o_status.suspended) |->
    !o_status.busy && !o_status.write_enable_latch && $past(o_status.busy))
    else $error("suspend entry status wrong");
  busy_start_a: assert property ($rose(o_status.busy) |-> i_cs_n)
    else $error("busy rose inside a frame");
  latch_start_a: assert property ($rose(o_status.write_enable_latch) |-> i_cs_n)
    else $error("latch rose inside a frame");
endmodule

bind sfl_core sfl_core_properties sfl_core_properties_i (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_cs_n(i_cs_n),
  .i_quad_command_mode(i_quad_command_mode),
  .o_io_oe(o_io_oe),
  .o_status(o_status)
);

/* sim/sfl_host_model.sv */
`timescale 1ns/1ps
module sfl_host_model (
  input wire logic i_ref_clk,
  input wire logic i_quad,
  input wire logic [3:0] i_miso,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_io
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h5;
  end
  task automatic half();
    repeat (4) @(negedge i_ref_clk);
  endtask
  // one frame: ntx bits out msb first, then nrx bits back
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                      output logic [127:0] rx);
    rx = '0;
    half();
    o_cs_n = 1'b0;
    for (int i = 0; i < ntx; i += (i_quad ? 4 : 1)) begin
      o_io = i_quad ? tx[63-i -: 4] : {3'b101, tx[63-i]};
      half();
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    o_io = ~o_io;
    for (int i = 0; i < nrx; i += (i_quad ? 4 : 1)) begin
      half();
      o_sclk = 1'b1;
      half();
      rx = i_quad ? {rx[123:0], i_miso} : {rx[126:0], i_miso[1]};
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    repeat (24) @(negedge i_ref_clk);
  endtask
endmodule

/* sim/flash_suspend_lock_reset_cmds_tb_top.sv */
`timescale 1ns/1ps
module flash_suspend_lock_reset_cmds_tb_top import sfl_pkg::*;;
  localparam logic [127:0] UID = 128'h5a3c_0f96_1e2d_4b78_c3a5_6699_0ff0_a55a; // arbitrary
  typedef struct {logic w; logic q; logic [39:0] tx; int n; logic [23:0] a; logic e;} sfl_tb_row_t;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic quad = 1'b0;
  logic psel = 1'b1;
  logic cs_n;
  logic sclk;
  logic [3:0] io;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  sfl_status_t st;
  logic [127:0] rx;
  int num_errors = 0;
  int compares = 0;
  sfl_tb_row_t rows [10] = '{
    '{1'b0, 1'b0, 40'h0, 0, 24'h010000, 1'b1},
    '{1'b1, 1'b0, 40'h98_0000_0000, 8, 24'h010000, 1'b0},
    '{1'b1, 1'b0, 40'h36_0200_0000, 32, 24'h020000, 1'b1},
    '{1'b0, 1'b0, 40'h0, 0, 24'h030000, 1'b0},
    '{1'b1, 1'b0, 40'h36_0010_0000, 32, 24'h001000, 1'b1},
    '{1'b0, 1'b0, 40'h0, 0, 24'h002000, 1'b0},
    '{1'b1, 1'b0, 40'h39_0200_0000, 32, 24'h020000, 1'b0},
    '{1'b0, 1'b0, 40'h36_0500_0000, 32, 24'h050000, 1'b0},
    '{1'b1, 1'b0, 40'h36_0400_0000, 33, 24'h040000, 1'b0},
    '{1'b1, 1'b1, 40'h7e_0000_0000, 8, 24'h050000, 1'b1}};
  always #20 i_ref_clk = ~i_ref_clk;
  sfl_core #(.PROG_CYCLES(1500), .ERASE_CYCLES(3000), .UNIQUE_ID(UID)) sfl_core_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(1'b1), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_io(io), .i_quad_command_mode(quad), .i_protection_select(psel),
    .i_protect_complement(1'b0), .i_block_protect_bits(5'h00),
    .o_io_out(io_out), .o_io_oe(io_oe), .o_status(st));
  sfl_host_model sfl_host_model_i (.i_ref_clk(i_ref_clk), .i_quad(quad), .i_miso(io_out),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_io(io));
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [63:0] tx, input int n);
    sfl_host_model_i.xfer(tx, n, 0, rx);
  endtask
  task automatic write_enable();
    cmd({8'h06, 56'h0}, 8);
  endtask
  task automatic soft_reset();
    cmd({8'h66, 56'h0}, 8);
    cmd({8'h99, 56'h0}, 8);
  endtask
  task automatic lock_rd(input logic [23:0] a, input logic e);
    sfl_host_model_i.xfer({8'h3d, a, 32'h0}, 32, 8, rx);
    check({120'h0, rx[7:0]}, {127'h0, e});
  endtask
  // bounded wait for a status bit
  task automatic wait_st(input int b, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && st[b] !== v; k++)
      @(negedge i_ref_clk);
    if (k == lim) begin
      num_errors++;
      $display("ERROR %0t: status wait timed out", $time);
      final_report();
    end
  endtask
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    check({124'h0, st}, 128'h0);
    foreach (rows[r]) begin
      quad = rows[r].q;
      if (rows[r].w)
        write_enable();
      if (rows[r].n > 0)
        cmd({rows[r].tx, 24'h0}, rows[r].n);
      lock_rd(rows[r].a, rows[r].e);
    end
    quad = 1'b0;
    write_enable();
    cmd({8'h98, 56'h0}, 8);
    cmd({8'h66, 56'h0}, 8);
    cmd({8'h00, 56'h0}, 8);
    cmd({8'h99, 56'h0}, 8);
    lock_rd(24'h010000, 1'b0);
    soft_reset();
    lock_rd(24'h010000, 1'b1);
    write_enable();
    cmd({8'h02, 24'h010000, 8'ha5, 24'h0}, 40);
    check({124'h0, st}, {124'h0, 4'b1000});
    soft_reset();
    check({124'h0, st}, {124'h0, 4'b1000});
    psel = 1'b0;
    write_enable();
    cmd({8'h02, 24'h010000, 8'ha5, 24'h0}, 40);
    check({127'h0, st.busy}, 128'h1);
    soft_reset();
    check({124'h0, st}, {124'h0, 4'b1000});
    psel = 1'b1;
    write_enable();
    cmd({8'h98, 56'h0}, 8);
    write_enable();
    cmd({8'h20, 24'h010000, 32'h0}, 32);
    cmd({8'h75, 56'h0}, 8);
    wait_st(2, 1'b1, 800);
    repeat (2) @(negedge i_ref_clk);
    check({124'h0, st}, {124'h0, 4'b1100});
    sfl_host_model_i.xfer({8'h35, 56'h0}, 8, 8, rx);
    check({127'h0, rx[7]}, 128'h1);
    write_enable();
    cmd({8'h02, 24'h010100, 8'h3c, 24'h0}, 40);
    check({127'h0, st.busy}, 128'h0);
    write_enable();
    cmd({8'h02, 24'h030000, 8'h3c, 24'h0}, 40);
    check({124'h0, st}, {124'h0, 4'b1111});
    cmd({8'h7a, 56'h0}, 8);
    check({124'h0, st}, {124'h0, 4'b1111});
    wait_st(1, 1'b0, 2000);
    repeat (6) @(negedge i_ref_clk);
    check({124'h0, st}, {124'h0, 4'b1100});
    cmd({8'h7a, 56'h0}, 8);
    check({124'h0, st}, {124'h0, 4'b1011});
    wait_st(1, 1'b0, 4000);
    sfl_host_model_i.xfer({8'h4b, 56'h0}, 40, 128, rx);
    check(rx, UID);
    final_report();
  end
endmodule
